// >>> design/pstmc_top.sv
// pin-state controller for ports 1..7 with an AXI4-Lite register file
// assumes synchronous inputs, mode straps stable around reset release,
// and an external pad ring that resolves pin_o/pin_oe/pullup into pins
//
// Functional notes
// - a pin that must be three-state has its output enable low.
// - an input pin holding its previous state stays undriven.
// - an input pin holding its previous state keeps its pull-up on when its pull-up bit is 1.
// - an output pin holding its previous state keeps driving its last level.
// - in plain I/O use the direction bit selects output (1) or input (0).
// - on-chip peripherals may take over a pin while they use it.
// - entering software standby resets the peripherals so pins of ports 4..6 follow direction and latch.
// - in mode 2 normal operation each address pin is an address output or an input port.
`timescale 1ns/100ps
`default_nettype none

module pstmc_top (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [1:0]                  mcu_mode,
    input  wire logic                        hw_standby_n,
    input  wire logic                        wake,
    input  wire logic [15:0]                 core_addr,
    input  wire logic                        core_addr_strobe,
    input  wire logic [7:0]                  core_data_o,
    input  wire logic                        core_data_oe,
    input  wire logic [47:0]                 periph_use,
    input  wire logic [47:0]                 periph_oe,
    input  wire logic [47:0]                 periph_out,
    input  wire logic [55:0]                 pin_i,
    output logic      [47:0]                 pin_o,
    output logic      [47:0]                 pin_oe,
    output logic      [47:0]                 pullup_en,
    output logic                             periph_rst,
    input  wire logic [7:0]                  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic      [1:0]                  bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [7:0]                  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic      [31:0]                 rdata,
    output logic      [1:0]                  rresp,
    output logic                             rvalid,
    input  wire logic                        rready
);

    // register state
    logic [47:0]              ddr_q, ddr_d, dr_q, dr_d, pcr_q, pcr_d;
    logic [1:0]               mode_q, mode_d;
    pstmc_pkg::pstmc_pwr_t    pwr_q, pwr_d;
    logic [15:0]              last_addr_q, last_addr_d;
    logic [47:0]              pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, pu_q, pu_d;
    logic                     prst_q, prst_d;
    // bus state
    logic [7:0]               aw_addr_q, aw_addr_d;
    logic [31:0]              w_data_q, w_data_d;
    logic                     w_strb0_q, w_strb0_d;
    logic                     aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic                     bvalid_q, bvalid_d, arready_q, arready_d;
    logic                     rvalid_q, rvalid_d;
    logic                     awready_q, awready_d, wready_q, wready_d;
    logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]              rdata_q, rdata_d;

    // true when an address names a register
    function automatic logic addr_ok(input logic [7:0] a);
        logic [3:0] p;
        logic [3:0] f;
        p = a[7:4];
        f = {a[3:2], 2'b00};
        if (p == 4'h0)
            return (a[3:0] == pstmc_pkg::OFF_CTRL[3:0]) || (a[3:0] == pstmc_pkg::OFF_STATUS[3:0]);
        if (p == pstmc_pkg::PORT_INONLY)
            return f == pstmc_pkg::OFF_PIN;
        return (p <= 4'(pstmc_pkg::NPORT_OUT)) && (a[1:0] == 2'b00);
    endfunction

    // pin behaviour of one driving bit: returns {oe, out, pull-up}
    function automatic logic [2:0] pin_bit(
        input int                    p,
        input logic [1:0]            mode,
        input pstmc_pkg::pstmc_pwr_t pwr,
        input logic                  ddr,
        input logic                  dr,
        input logic                  pullup_control_bit,
        input logic                  oe_prev,
        input logic                  out_prev,
        input logic                  a_now,
        input logic                  a_last,
        input logic                  d_out,
        input logic                  d_oe,
        input logic                  puse,
        input logic                  poe,
        input logic                  pout);
        logic oe;
        logic out;
        logic bus;
        oe  = ddr;
        out = dr;
        bus = 1'b0;
        if (p <= pstmc_pkg::ADDR_PORTS && mode == pstmc_pkg::MODE1) begin
            // fixed address outputs; low in software standby
            bus = 1'b1;
            oe  = 1'b1;
            out = (pwr == pstmc_pkg::PWR_NORMAL) ? a_now
                : (pwr == pstmc_pkg::PWR_SLEEP) ? a_last : 1'b0;
        end else if (p <= pstmc_pkg::ADDR_PORTS && mode == pstmc_pkg::MODE2) begin
            // per bit: address output if ddr, else input port
            oe  = ddr;
            if (pwr == pstmc_pkg::PWR_NORMAL)
                out = a_now;
            else if (pwr == pstmc_pkg::PWR_SLEEP)
                out = a_last;
            else if (ddr)
                out = 1'b0;
            else begin
                oe  = 1'b0;
                out = out_prev;
            end
        end else if (p == pstmc_pkg::DATA_PORT && mode != pstmc_pkg::MODE3) begin
            // data bus: driven only while the core writes, else three-state
            bus = 1'b1;
            oe  = (pwr == pstmc_pkg::PWR_NORMAL) && d_oe;
            out = d_out;
        end else if (pwr == pstmc_pkg::PWR_NORMAL) begin
            if (puse) begin
                oe  = poe;
                out = pout;
            end else begin
                oe  = ddr;
                out = dr;
            end
        end else if (pwr == pstmc_pkg::PWR_SWSTBY && p >= pstmc_pkg::GPIO_FIRST) begin
            // peripherals are in reset, so the port latches take over
            oe  = ddr;
            out = dr;
        end else begin
            // previous state: inputs stay undriven, outputs hold level
            oe  = oe_prev;
            out = out_prev;
        end
        return {oe, out, pullup_control_bit & ~oe & ~bus};
    endfunction

    // mode strap caught while reset is held, power state and address memory
    always_comb begin
        mode_d      = mode_q;
        pwr_d       = pwr_q;
        last_addr_d = last_addr_q;
        if (!aresetn) begin
            // an unused strap code falls back to single-chip mode
            mode_d = (mcu_mode == 2'h0) ? pstmc_pkg::MODE3 : mcu_mode;
            pwr_d  = pstmc_pkg::PWR_NORMAL;
            last_addr_d = 16'h0000;
        end else begin
            if (pwr_q == pstmc_pkg::PWR_NORMAL && core_addr_strobe)
                last_addr_d = core_addr;
            if (aw_have_q && w_have_q && !bvalid_q && w_strb0_q && aw_addr_q == pstmc_pkg::OFF_CTRL
                && w_data_q[pstmc_pkg::CTRL_PWR_LSB +: 2] != 2'h3)
                pwr_d = pstmc_pkg::pstmc_pwr_t'(w_data_q[pstmc_pkg::CTRL_PWR_LSB +: 2]);
            // a wake event beats a same-cycle software write
            if (wake || !hw_standby_n)
                pwr_d = pstmc_pkg::PWR_NORMAL;
        end
        prst_d = aresetn && pwr_d == pstmc_pkg::PWR_SWSTBY && pwr_q != pstmc_pkg::PWR_SWSTBY;
    end

    // pin drive, pull-ups; hardware standby and reset override everything
    always_comb begin
        logic [2:0] st;
        st = 3'b000;
        for (int i = 0; i < pstmc_pkg::NBIT_OUT; i++) begin
            st = pin_bit(i / pstmc_pkg::PORT_W + 1, mode_q, pwr_q, ddr_q[i], dr_q[i], pcr_q[i],
                         pin_oe_q[i], pin_o_q[i], (i < 16) ? core_addr[i % 16] : 1'b0,
                         (i < 16) ? last_addr_q[i % 16] : 1'b0, core_data_o[i % 8],
                         core_data_oe, periph_use[i], periph_oe[i], periph_out[i]);
            if (!hw_standby_n) begin
                st = 3'b000;
            end else if (!aresetn) begin
                // address pins of mode 1 are driven low in reset, the rest float
                st = {(i < 16) && (mode_d == pstmc_pkg::MODE1), 2'b00};
            end
            pin_oe_d[i] = st[2];
            pin_o_d[i]  = st[1];
            pu_d[i]     = st[0];
        end
    end

    // bus channels: write address and data taken in either order
    always_comb begin
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb0_d = w_strb0_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        ddr_d     = ddr_q;
        dr_d      = dr_q;
        pcr_d     = pcr_q;
        if (awvalid && !aw_have_q && !bvalid_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = {awaddr[7:2], 2'b00};
        end
        if (wvalid && !w_have_q && !bvalid_q) begin
            w_have_d  = 1'b1;
            w_data_d  = wdata;
            w_strb0_d = wstrb[0];
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            // registers hold 8 bits, so only byte lane 0 matters
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = addr_ok(aw_addr_q) ? pstmc_pkg::RESP_OKAY : pstmc_pkg::RESP_SLVERR;
            if (w_strb0_q && aw_addr_q[7:4] >= 4'h1 && aw_addr_q[7:4] <= 4'(pstmc_pkg::NPORT_OUT)) begin
                unique case (aw_addr_q[3:0])
                    pstmc_pkg::OFF_DDR: ddr_d[(aw_addr_q[7:4] - 4'h1) * 8 +: 8] = w_data_q[7:0];
                    pstmc_pkg::OFF_DR:  dr_d[(aw_addr_q[7:4] - 4'h1) * 8 +: 8]  = w_data_q[7:0];
                    pstmc_pkg::OFF_PCR: pcr_d[(aw_addr_q[7:4] - 4'h1) * 8 +: 8] = w_data_q[7:0];
                    default: ;
                endcase
            end
        end
        if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = addr_ok(araddr) ? pstmc_pkg::RESP_OKAY : pstmc_pkg::RESP_SLVERR;
            rdata_d  = 32'h0000_0000;
            if (araddr[7:4] == 4'h0) begin
                if (araddr[3:2] == pstmc_pkg::OFF_CTRL[3:2])
                    rdata_d[pstmc_pkg::CTRL_PWR_LSB +: 2] = pwr_q;
                else if (araddr[3:2] == pstmc_pkg::OFF_STATUS[3:2]) begin
                    rdata_d[pstmc_pkg::STAT_MODE_LSB +: 2]  = mode_q;
                    rdata_d[pstmc_pkg::STAT_HWSTBY_BIT]     = ~hw_standby_n;
                end
            end else if (araddr[7:4] <= pstmc_pkg::PORT_INONLY) begin
                unique case ({araddr[3:2], 2'b00})
                    pstmc_pkg::OFF_DDR: rdata_d[7:0] = (araddr[7:4] == pstmc_pkg::PORT_INONLY) ? 8'h00
                                                     : ddr_q[(araddr[7:4] - 4'h1) * 8 +: 8];
                    pstmc_pkg::OFF_DR:  rdata_d[7:0] = (araddr[7:4] == pstmc_pkg::PORT_INONLY) ? 8'h00
                                                     : dr_q[(araddr[7:4] - 4'h1) * 8 +: 8];
                    pstmc_pkg::OFF_PCR: rdata_d[7:0] = (araddr[7:4] == pstmc_pkg::PORT_INONLY) ? 8'h00
                                                     : pcr_q[(araddr[7:4] - 4'h1) * 8 +: 8];
                    default:            rdata_d[7:0] = pin_i[(araddr[7:4] - 4'h1) * 8 +: 8];
                endcase
            end
        end else if (rvalid_q && rready)
            rvalid_d = 1'b0;
        arready_d = ~rvalid_d;
        if (!aresetn) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b0;
            rvalid_d  = 1'b0;
            arready_d = 1'b0;
            ddr_d     = {pstmc_pkg::NPORT_OUT{pstmc_pkg::DDR_RST}};
            dr_d      = {pstmc_pkg::NPORT_OUT{pstmc_pkg::DR_RST}};
            pcr_d     = {pstmc_pkg::NPORT_OUT{pstmc_pkg::PCR_RST}};
        end
        // readies come from next state so the ports leave flops with no extra cycle
        awready_d = ~aw_have_d & ~bvalid_d;
        wready_d  = ~w_have_d & ~bvalid_d;
    end

    // every state element registers its next value
    always_ff @(posedge aclk) begin
        mode_q      <= mode_d;
        pwr_q       <= pwr_d;
        last_addr_q <= last_addr_d;
        prst_q      <= prst_d;
        pin_o_q     <= pin_o_d;
        pin_oe_q    <= pin_oe_d;
        pu_q        <= pu_d;
        ddr_q       <= ddr_d;
        dr_q        <= dr_d;
        pcr_q       <= pcr_d;
        aw_addr_q   <= aw_addr_d;
        w_data_q    <= w_data_d;
        w_strb0_q   <= w_strb0_d;
        aw_have_q   <= aw_have_d;
        w_have_q    <= w_have_d;
        bvalid_q    <= bvalid_d;
        bresp_q     <= bresp_d;
        arready_q   <= arready_d;
        rvalid_q    <= rvalid_d;
        rresp_q     <= rresp_d;
        rdata_q     <= rdata_d;
        awready_q   <= awready_d;
        wready_q    <= wready_d;
    end

    // outputs straight from flip-flops
    assign pin_o      = pin_o_q;
    assign pin_oe     = pin_oe_q;
    assign pullup_en  = pu_q;
    assign periph_rst = prst_q;
    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rresp      = rresp_q;
    assign rdata      = rdata_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_hwstby_float: assert property (
        $past(aresetn) && !$past(hw_standby_n) |-> pin_oe_q == 48'h0)
        else $error("pins driven during hardware standby");
    a_sleep_hold: assert property (
        pwr_q == pstmc_pkg::PWR_SLEEP && $past(pwr_q) == pstmc_pkg::PWR_SLEEP
        && hw_standby_n && $past(hw_standby_n) && $past(aresetn)
        |=> pin_oe_q[47:24] == $past(pin_oe_q[47:24])
        && pin_o_q[47:24] == $past(pin_o_q[47:24]))
        else $error("port state not held in sleep");
    a_input_pullup: assert property (
        pwr_q == pstmc_pkg::PWR_SLEEP && hw_standby_n && $past(aresetn)
        |=> pu_q[47:24] == ($past(pcr_q[47:24]) & ~pin_oe_q[47:24])
        && (pu_q & pin_oe_q) == 48'h0)
        else $error("pull-up wrong on held input");
    a_dir_follows: assert property (
        pwr_q == pstmc_pkg::PWR_NORMAL && mode_q == pstmc_pkg::MODE3
        && periph_use == 48'h0 && hw_standby_n && $past(aresetn)
        |=> pin_oe_q == $past(ddr_q) && pin_o_q == $past(dr_q))
        else $error("pin direction does not follow ddr");
    a_periph_owns: assert property (
        pwr_q == pstmc_pkg::PWR_NORMAL && hw_standby_n && $past(aresetn)
        |=> ((pin_oe_q ^ $past(periph_oe)) & $past(periph_use) & {24'hff_ffff, 24'h0}) == 48'h0)
        else $error("peripheral does not own its pin");
    // pins one cycle after entry still come from the standby state, so no wake escape here
    a_swstby_reset: assert property (
        pwr_q == pstmc_pkg::PWR_SWSTBY && $past(pwr_q) != pstmc_pkg::PWR_SWSTBY
        && $past(aresetn) |-> prst_q
        ##1 (!$past(hw_standby_n) || pin_oe_q[47:24] == $past(ddr_q[47:24])))
        else $error("software standby entry mishandled");
    a_mode2_addr: assert property (
        pwr_q == pstmc_pkg::PWR_NORMAL && mode_q == pstmc_pkg::MODE2
        && hw_standby_n && $past(aresetn)
        |=> pin_oe_q[15:0] == $past(ddr_q[15:0])
        && (pin_o_q[15:0] & pin_oe_q[15:0]) == ($past(core_addr) & pin_oe_q[15:0]))
        else $error("mode 2 address pin wrong");
    // modes 1 and 2 both put the last address on pin_o of every address pin in sleep; mode 2 drives only its ddr bits
    a_sleep_addr: assert property (
        pwr_q == pstmc_pkg::PWR_SLEEP && mode_q != pstmc_pkg::MODE3
        && hw_standby_n && $past(aresetn) |=> pin_o_q[15:0] == $past(last_addr_q))
        else $error("sleep address not held");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer lost");

    c_sleep_entry: cover property (pwr_q == pstmc_pkg::PWR_NORMAL ##1 pwr_q == pstmc_pkg::PWR_SLEEP);
    c_swstby_entry: cover property (prst_q);
    c_write_done: cover property (bvalid && bready);

endmodule

`default_nettype wire

// >>> design/pstmc_pkg.sv
// constants and types for the port pin-state controller
// assumes a single 200 MHz clock domain and an AXI4-Lite register port
package pstmc_pkg;

    // operating modes latched from the mode straps
    localparam logic [1:0] MODE1 = 2'h1;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [1:0] MODE3 = 2'h3;

    // power states of the core as seen by the pin logic
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_SLEEP,
        PWR_SWSTBY
    } pstmc_pwr_t;

    // geometry: ports 1..6 can drive, port 7 is input only
    localparam int PORT_W     = 8;
    localparam int NPORT_OUT  = 6;
    localparam int NBIT_OUT   = 48;
    localparam int NBIT_IN    = 56;
    localparam int ADDR_PORTS = 2;
    localparam int DATA_PORT  = 3;
    localparam int GPIO_FIRST = 4;

    // register map: byte address = port number in bits 7:4, field in 3:0
    localparam int         AXI_AW       = 8;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [3:0] OFF_DDR      = 4'h0;
    localparam logic [3:0] OFF_DR       = 4'h4;
    localparam logic [3:0] OFF_PCR      = 4'h8;
    localparam logic [3:0] OFF_PIN      = 4'hc;
    localparam logic [3:0] PORT_INONLY  = 4'h7;

    // field positions
    localparam int CTRL_PWR_LSB    = 0;
    localparam int STAT_MODE_LSB   = 0;
    localparam int STAT_HWSTBY_BIT = 2;

    // reset values
    localparam logic [7:0] DDR_RST = 8'h00;
    localparam logic [7:0] DR_RST  = 8'h00;
    localparam logic [7:0] PCR_RST = 8'h00;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> verif/pstmc_pin_model.sv
// external devices hanging on the port pins, ports 1..7
// assumes the bench steers ext_en/ext_val and the design owns pin_o/pin_oe
`timescale 1ns/100ps
`default_nettype none

module pstmc_pin_model (
    input  wire logic        aclk,
    input  wire logic [47:0] pin_o,
    input  wire logic [47:0] pin_oe,
    input  wire logic [47:0] pullup_en,
    input  wire logic [55:0] ext_en,
    input  wire logic [55:0] ext_val,
    output logic      [55:0] pin_i
);
    logic [55:0] noise_q = 56'h0;
    logic [55:0] oe_w;
    logic [55:0] pu_w;

    // a floating line wanders each cycle so a stale level never passes as driven
    always_ff @(posedge aclk) begin
        noise_q <= ~noise_q;
    end

    // port 7 has no drive and no pull-up on the chip side
    assign oe_w = {8'h00, pin_oe};
    assign pu_w = {8'h00, pullup_en};

    // wire level: chip drive, then device drive, then pull-up, else noise
    always_comb begin
        for (int i = 0; i < 56; i++) begin
            if (oe_w[i]) begin
                pin_i[i] = oe_w[i] & pin_o[i % 48];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else if (pu_w[i]) begin
                pin_i[i] = 1'b1;
            end else begin
                pin_i[i] = noise_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/pstmc_tb_top.sv
// self-checking bench for the port pin-state controller
// assumes the pin model in verif/ and the design files in design/
`timescale 1ns/100ps
`default_nettype none

module pstmc_tb_top;
    logic        aclk, aresetn, hw_standby_n, wake, core_addr_strobe, core_data_oe;
    logic        awvalid, wvalid, bready, arvalid, rready, periph_rst;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  mcu_mode, bresp, rresp, resp;
    logic [7:0]  awaddr, araddr, core_data_o, ddr, dr, pullup_control_bit;
    logic [15:0] core_addr, seed, addr_a;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [47:0] periph_use, periph_oe, periph_out, pin_o, pin_oe, pullup_en;
    logic [55:0] pin_i, ext_en, ext_val;
    int          num_errors, checks_done, cycles, p, pulses;

    pstmc_top dut_u (.aclk, .aresetn, .mcu_mode, .hw_standby_n, .wake, .core_addr,
        .core_addr_strobe, .core_data_o, .core_data_oe, .periph_use, .periph_oe,
        .periph_out, .pin_i, .pin_o, .pin_oe, .pullup_en, .periph_rst, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    pstmc_pin_model pins_u (.aclk, .pin_o, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_i);

    // 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // hang guard, also counts the peripheral reset pulses
    always @(posedge aclk) begin
        cycles++;
        if (periph_rst === 1'b1) pulses++;
        if (cycles == 20000) begin
            num_errors++;
            $display("unexpected timeout: expected end of run, seen %0d cycles", cycles);
            complete_run();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk_val(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // the leading edge keeps back-to-back calls from assigning twice in one step
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // mode is latched while reset is low; only mode 1 drives ports 1/2 low then
    task automatic do_reset(input logic [1:0] m);
        @(posedge aclk);
        aresetn <= 1'b0;
        mcu_mode <= m;
        repeat (6) @(posedge aclk);
        chk_val("reset oe", (m == pstmc_pkg::MODE1) ? 48'hffff : 48'h0, pin_oe);
        chk_val("reset level", 48'h0, pin_o & pin_oe);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence: reset, address pins, random gpio, takeover, standby
    initial begin
        {aresetn, hw_standby_n, wake, core_addr_strobe, core_data_oe} = 5'b01000;
        {awvalid, wvalid, bready, arvalid, rready, wstrb} = {5'h0, 4'hf};
        {mcu_mode, core_addr, core_data_o, awaddr, araddr, wdata} = '0;
        {periph_use, periph_oe, periph_out, ext_en, ext_val} = '0;
        seed = 16'h0014;
        do_reset(pstmc_pkg::MODE1);
        $display("test reset_mode1 done");
        do_reset(pstmc_pkg::MODE2);
        seed = lfsr(seed);
        addr_a = seed;
        core_addr <= addr_a;
        core_addr_strobe <= 1'b1;
        core_data_o <= addr_a[15:8];
        core_data_oe <= 1'b1;
        @(posedge aclk);
        core_addr_strobe <= 1'b0;
        axi_wr(8'h10, 8'hff);
        axi_wr(8'h20, 8'h00);
        repeat (2) @(posedge aclk);
        chk_val("addr oe", 48'h00ff, {32'h0, pin_oe[15:0]});
        chk_val("addr out", {40'h0, addr_a[7:0]}, {40'h0, pin_o[7:0]});
        chk_val("data drive", {32'h0, addr_a[15:8], 8'hff},
                {32'h0, pin_o[23:16], pin_oe[23:16]});
        axi_wr(pstmc_pkg::OFF_CTRL, 8'h01);
        core_addr <= ~addr_a;
        repeat (3) @(posedge aclk);
        chk_val("sleep addr", {40'h0, addr_a[7:0]}, {40'h0, pin_o[7:0]});
        chk_val("data float", 48'h0, {40'h0, pin_oe[23:16]});
        $display("test address_pins done");
        do_reset(pstmc_pkg::MODE3);
        ext_en <= {8'hff, 48'h0};
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            {dr, ddr} = seed;
            seed = lfsr(seed);
            pullup_control_bit = seed[7:0];
            p = 4 + i % 3;
            ext_val <= {seed[15:8], 48'h0};
            axi_wr(8'(p * 16), ddr);
            axi_wr(8'(p * 16 + 4), dr);
            axi_wr(8'(p * 16 + 8), pullup_control_bit);
            repeat (2) @(posedge aclk);
            chk_val("gpio oe", {40'h0, ddr}, {40'h0, pin_oe[(p-1)*8 +: 8]});
            chk_val("gpio out", {40'h0, dr & ddr}, {40'h0, pin_o[(p-1)*8 +: 8] & ddr});
            chk_val("pullup", {40'h0, pullup_control_bit & ~ddr}, {40'h0, pullup_en[(p-1)*8 +: 8]});
            axi_rd(8'h7c);
            chk_val("port7 pins", {40'h0, seed[15:8]}, {16'h0, rd});
        end
        axi_rd(8'hf0);
        chk_resp("unmapped read", pstmc_pkg::RESP_SLVERR, resp);
        axi_wr(8'hf0, 8'h5a);
        chk_resp("unmapped write", pstmc_pkg::RESP_SLVERR, resp);
        $display("test random_gpio done");
        axi_wr(8'h40, 8'h0f);
        axi_wr(8'h44, 8'h05);
        axi_wr(8'h10, 8'h0f);
        axi_wr(8'h14, 8'h05);
        axi_wr(8'h18, 8'hf0);
        seed = lfsr(seed);
        periph_use <= 48'hff << 24;
        periph_oe <= 48'hff << 24;
        periph_out <= {16'h0, seed[7:0], 24'h0};
        repeat (3) @(posedge aclk);
        chk_val("takeover", {seed[7:0], 8'hff}, {32'h0, pin_o[31:24], pin_oe[31:24]});
        pulses = 0;
        axi_wr(pstmc_pkg::OFF_CTRL, 8'h02);
        axi_wr(8'h14, 8'h0a);
        repeat (3) @(posedge aclk);
        chk_val("periph reset", 48'h1, 48'(pulses));
        chk_val("standby port4", 48'h050f, {32'h0, pin_o[31:24] & 8'h0f, pin_oe[31:24]});
        chk_val("standby port1", 48'h050f, {32'h0, pin_o[7:0] & 8'h0f, pin_oe[7:0]});
        chk_val("standby pullup", 48'hf0, {40'h0, pullup_en[7:0]});
        wake <= 1'b1;
        @(posedge aclk);
        wake <= 1'b0;
        $display("test standby done");
        hw_standby_n <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_val("hw standby oe", 48'h0, pin_oe);
        hw_standby_n <= 1'b1;
        $display("test hw_standby done");
        complete_run();
    end
endmodule
`default_nettype wire
